// [design/frame_codec_defines.svh]
`ifndef FRAME_CODEC_DEFINES_SVH
`define FRAME_CODEC_DEFINES_SVH
`define CHECK_MAGIC 16'h4242
`define TYPE_DATA 8'h00
`define TYPE_REMOTE 8'h02
`define TYPE_MEMORY 8'h03
`define TYPE_SAMPLE 8'h04
`define TYPE_DATA_ACK 8'h80
`define TYPE_REMOTE_RSP 8'h82
`define TYPE_MEMORY_RSP 8'h83
`define OPT_ACK_BIT 1
`define HDR_LEN 16'h0008
`define MAX_PAYLOAD 16'h05D4
`define SAMPLE_SRC_PORT 16'h0BEE
`define SAMPLE_SETS 8'h01
`endif

// [design/frame_codec_pkg.sv]
package frame_codec_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_beat_t;

    typedef struct packed {
        logic [15:0] dig_mask;
        logic [7:0] ana_mask;
        logic [15:0] dig_level;
        logic [7:0][9:0] ana_value;
    } sample_req_t;

    typedef struct packed {
        logic [31:0] dest_ip;
        logic [15:0] src_port;
    } udp_tag_t;
endpackage

// [design/app_service_frame_codec.sv]
`timescale 1ns/1ns
`include "frame_codec_defines.svh"

// Behaviour
// [RULE1] Accept frame only if check words XOR 0x4242
// [RULE2] Sequence and pad bytes sent as zero
// [RULE3] Offset six byte selects frame type
// [RULE4] Options bit one requests acknowledgement, others zero
// [RULE5] Data frame payload from offset eight forwarded
// [RULE6] Acknowledge with type 0x80, zero options
// [RULE7] Client waits for acknowledgement before next command
// [RULE8] Client retransmits; device never retransmits itself
// [RULE9] Host tolerates duplicate payloads from retransmission
// [RULE10] Samples sent from port 0xBEE to destination
// [RULE11] Sample frame type 0x04, options zero
// [RULE12] Offset eight holds sample set count
// [RULE13] Offsets nine, ten hold digital mask
// [RULE14] Offset eleven holds analog enable mask
// [RULE15] Digital word present only when lines enabled
// [RULE16] Analog readings two bytes, MSB first
// [RULE17] Analog readings ascending after digital word
// [RULE18] Bad frames dropped silently, no acknowledgement
module app_service_frame_codec
    import frame_codec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rx_valid,
    input wire frame_codec_pkg::byte_beat_t rx_beat,
    output logic rx_ready,
    output logic ser_valid,
    output frame_codec_pkg::byte_beat_t ser_beat,
    input wire logic ser_ready,
    input wire logic [31:0] destination_ip_setting,
    input wire logic sample_start,
    input wire frame_codec_pkg::sample_req_t sample_req,
    output logic sample_busy,
    output logic tx_valid,
    output frame_codec_pkg::byte_beat_t tx_beat,
    output frame_codec_pkg::udp_tag_t tx_tag,
    input wire logic tx_ready,
    output logic rx_drop_q
);
    import frame_codec_pkg::*;

    // Reset is released through two flops so that release is clean.
    // Only the second flop is read by the rest of the design.
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Receive parser. Header bytes are kept until offset 7 is known, so
    // a frame is judged before any payload reaches the serial side.
    logic [15:0] rx_cnt_q;
    logic [15:0] word0_q;
    logic [15:0] word1_q;
    logic [7:0] type_q;
    logic ack_req_q;
    logic good_q;
    logic ack_pend_q;

    // Two-entry skid buffer between parser and serial port.
    logic [1:0] buf_cnt_q;
    byte_beat_t buf_q [2];

    // Header decode. Only a good data frame may push payload or ask for
    // an ack, so a bad header never reaches either output.
    wire rx_fire = rx_valid && rx_ready;
    wire in_payload = rx_cnt_q >= `HDR_LEN;
    wire pay_ok = good_q && (type_q == `TYPE_DATA) &&
        (rx_cnt_q < (`HDR_LEN + `MAX_PAYLOAD));
    wire hdr_done = rx_fire && (rx_cnt_q == 16'd7);
    wire check_ok = ((word0_q ^ word1_q) == `CHECK_MAGIC); // [RULE1]
    wire type_ok = (type_q == `TYPE_DATA) || (type_q == `TYPE_REMOTE) ||
        (type_q == `TYPE_MEMORY); // [RULE3]
    wire frame_good = check_ok && type_ok; // [RULE18]
    wire push = rx_fire && in_payload && pay_ok; // [RULE5]
    wire pop = ser_valid && ser_ready;
    wire [1:0] buf_cnt_d = buf_cnt_q + {1'b0, push} - {1'b0, pop};
    wire ack_fire_ok = rx_fire && rx_beat.last && (good_q ||
        (rx_cnt_q == 16'd7 && frame_good)) &&
        (rx_cnt_q == 16'd7 ? (type_q == `TYPE_DATA) && rx_beat.data[1]
        : (type_q == `TYPE_DATA) && ack_req_q); // [RULE4]

    // Parser counter and captured header fields.
    // Reserved header bytes are not checked on receive.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_cnt_q <= 16'h0000;
            word0_q <= 16'h0000;
            word1_q <= 16'h0000;
            type_q <= 8'h00;
            ack_req_q <= 1'b0;
            good_q <= 1'b0;
        end else if (rx_fire) begin
            rx_cnt_q <= rx_beat.last ? 16'h0000 : rx_cnt_q + 16'h0001;
            case (rx_cnt_q)
                16'd0: word0_q[15:8] <= rx_beat.data;
                16'd1: word0_q[7:0] <= rx_beat.data;
                16'd2: word1_q[15:8] <= rx_beat.data;
                16'd3: word1_q[7:0] <= rx_beat.data;
                16'd6: type_q <= rx_beat.data;
                16'd7: begin
                    ack_req_q <= rx_beat.data[`OPT_ACK_BIT]; // [RULE4]
                    good_q <= frame_good; // [RULE1]
                end
                default: ;
            endcase
            if (rx_beat.last) begin
                good_q <= 1'b0;
            end
        end
    end

    // Drop flag pulses for one cycle when a header fails the checks.
    // Frames that end before the options byte are dropped without it.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_drop_q <= 1'b0;
        end else begin
            rx_drop_q <= hdr_done && !frame_good; // [RULE18]
        end
    end

    // Skid buffer storage; the head entry always sits at index 0.
    // A write lands behind whichever entry survives this cycle's pop.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            buf_cnt_q <= 2'd0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (pop) begin
                buf_q[0] <= buf_q[1];
            end
            if (push) begin
                buf_q[(buf_cnt_q - {1'b0, pop}) == 2'd0 ? 0 : 1] <= rx_beat;
            end
            buf_cnt_q <= buf_cnt_d;
        end
    end

    // Serial output registered from the buffer head.
    // Popping the only entry leaves a bubble; it costs rate, not data.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ser_valid <= 1'b0;
            ser_beat <= '0;
        end else if (!ser_valid || ser_ready) begin
            ser_valid <= 1'b0;
            if (buf_cnt_q != 2'd0 && !(pop && buf_cnt_q == 2'd1)) begin
                ser_valid <= 1'b1;
                ser_beat <= pop ? buf_q[1] : buf_q[0];
            end
        end
    end

    // Transmit sequencer. Acks take priority over sample reports; the
    // device never resends on its own. [RULE8]
    typedef enum logic [1:0] {TX_IDLE, TX_ACK, TX_SAMPLE} tx_state_t;
    tx_state_t tx_state_q;
    logic [5:0] tx_idx_q;
    logic [5:0] tx_len_q;
    sample_req_t samp_q;
    logic [7:0][9:0] ana_sel;
    logic [3:0] ana_cnt;
    logic [7:0] tx_byte;

    // Pack enabled channel values in ascending order. [RULE17]
    // A channel's slot is the count of enabled channels below it.
    always_comb begin
        ana_sel = '0;
        ana_cnt = 4'd0;
        for (int i = 0; i < 8; i++) begin
            if (samp_q.ana_mask[i]) begin
                ana_sel[ana_cnt[2:0]] = samp_q.ana_value[i];
                ana_cnt = ana_cnt + 4'd1;
            end
        end
    end

    // Only the first check word is nonzero, so the XOR test passes.
    wire [15:0] check_const = `CHECK_MAGIC; // [RULE1]

    // Sample frame layout: readings start at offset 14 when the digital
    // word is present and at offset 12 otherwise.
    wire dig_on = samp_q.dig_mask != 16'h0000; // [RULE15]
    wire [5:0] ana_base = dig_on ? 6'd14 : 6'd12;
    wire [5:0] ana_off = tx_idx_q - ana_base;
    wire [9:0] ana_word = ana_sel[ana_off[3:1]];

    // Byte at the current index of the frame being sent.
    // Offsets from 12 on depend on which fields the request enables.
    always_comb begin
        case (tx_idx_q)
            6'd0: tx_byte = check_const[15:8]; // [RULE1]
            6'd1: tx_byte = check_const[7:0];
            6'd2, 6'd3, 6'd4, 6'd5, 6'd7: tx_byte = 8'h00; // [RULE2]
            6'd6: tx_byte = (tx_state_q == TX_ACK) ? `TYPE_DATA_ACK
                : `TYPE_SAMPLE; // [RULE6] [RULE11]
            6'd8: tx_byte = `SAMPLE_SETS; // [RULE12]
            6'd9: tx_byte = samp_q.dig_mask[15:8]; // [RULE13]
            6'd10: tx_byte = samp_q.dig_mask[7:0];
            6'd11: tx_byte = samp_q.ana_mask; // [RULE14]
            default: begin
                if (dig_on && tx_idx_q == 6'd12) begin
                    tx_byte = samp_q.dig_level[15:8]; // [RULE15]
                end else if (dig_on && tx_idx_q == 6'd13) begin
                    tx_byte = samp_q.dig_level[7:0];
                end else if (!ana_off[0]) begin
                    tx_byte = {6'h00, ana_word[9:8]}; // [RULE16]
                end else begin
                    tx_byte = ana_word[7:0];
                end
            end
        endcase
    end

    // The output stage moves when empty or drained; a frame ends when its
    // last byte is loaded; only the end of an ack frame releases a pending ack.
    wire tx_adv = !tx_valid || tx_ready;
    wire [5:0] samp_len = ana_base + {1'b0, ana_cnt, 1'b0};
    wire tx_end = tx_adv && (tx_idx_q == tx_len_q - 6'd1);
    wire ack_clr = (tx_state_q == TX_ACK) && tx_end;
    wire ack_pend_d = ack_fire_ok || (ack_pend_q && !ack_clr); // [RULE6]

    // Accept is registered from next-state values, so the source sees a
    // flop while the timing matches a combinational accept.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= (buf_cnt_d != 2'd2) && !ack_pend_d;
        end
    end

    // Frame sequencer state.
    // A sample report waits in idle while an ack is pending.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_state_q <= TX_IDLE;
            tx_idx_q <= 6'd0;
            tx_len_q <= 6'd0;
            samp_q <= '0;
            ack_pend_q <= 1'b0;
            sample_busy <= 1'b0;
        end else begin
            ack_pend_q <= ack_pend_d; // [RULE6]
            if (sample_start && !sample_busy) begin
                samp_q <= sample_req;
                sample_busy <= 1'b1;
            end
            case (tx_state_q)
                TX_IDLE: begin
                    tx_idx_q <= 6'd0;
                    if (ack_pend_q) begin
                        tx_state_q <= TX_ACK;
                        tx_len_q <= 6'd8; // [RULE6]
                    end else if (sample_busy) begin
                        tx_state_q <= TX_SAMPLE;
                        tx_len_q <= samp_len;
                    end
                end
                TX_ACK, TX_SAMPLE: begin
                    if (tx_adv) begin
                        tx_idx_q <= tx_idx_q + 6'd1;
                        if (tx_idx_q == tx_len_q - 6'd1) begin
                            tx_state_q <= TX_IDLE;
                            if (tx_state_q == TX_SAMPLE) begin
                                sample_busy <= 1'b0;
                            end
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Registered transmit stream and datagram tag.
    // The tag moves only with the stage, so it stands with its byte.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_valid <= 1'b0;
            tx_beat <= '0;
            tx_tag <= '0;
        end else if (tx_adv) begin
            tx_valid <= tx_state_q != TX_IDLE;
            tx_beat.data <= tx_byte;
            tx_beat.last <= tx_idx_q == tx_len_q - 6'd1;
            tx_tag.src_port <= `SAMPLE_SRC_PORT; // [RULE10]
            tx_tag.dest_ip <= destination_ip_setting;
        end
    end
endmodule

// [dv/app_service_frame_codec_properties.sv]
`timescale 1ns/1ns
// Watches outgoing framing and the hold rules of both output streams.
module app_service_frame_codec_properties
    import frame_codec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rx_drop_q,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire frame_codec_pkg::byte_beat_t tx_beat,
    input wire frame_codec_pkg::udp_tag_t tx_tag,
    input wire logic ser_valid,
    input wire logic ser_ready,
    input wire frame_codec_pkg::byte_beat_t ser_beat,
    input wire logic sample_start,
    input wire logic sample_busy,
    input wire logic [31:0] destination_ip_setting
);
    logic [7:0] idx_q;
    logic [7:0] type_q;
    wire tx_hs = tx_valid && tx_ready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Byte position in the frame; the type is kept to judge frame length.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            idx_q <= 8'h00;
            type_q <= 8'h00;
        end else if (tx_hs) begin
            idx_q <= tx_beat.last ? 8'h00 : idx_q + 8'h01;
            type_q <= (idx_q == 8'h06) ? tx_beat.data : type_q;
        end
    end
    sequence s_tx_wait;
        tx_valid && !tx_ready;
    endsequence
    sequence s_tx_held;
        tx_valid && $stable(tx_beat);
    endsequence
    a_tx_holds: assert property (s_tx_wait |=> s_tx_held)
        else $error("tx byte changed while stalled");
    a_ser_holds: assert property (ser_valid && !ser_ready |=>
        ser_valid && $stable(ser_beat)) else $error("ser byte changed");
    a_src_port: assert property (tx_valid |->
        tx_tag.src_port == 16'h0BEE) else $error("bad source port");
    a_dest_addr: assert property (tx_valid |->
        tx_tag.dest_ip == destination_ip_setting) else $error("bad dest");
    a_drop_pulse: assert property (rx_drop_q |=> !rx_drop_q)
        else $error("drop flag longer than a cycle");
    a_busy_set: assert property (sample_start && !sample_busy |=>
        sample_busy) else $error("sample not captured");
    a_head_magic: assert property (tx_valid && idx_q < 8'h02 |->
        tx_beat.data == 8'h42) else $error("bad check word");
    a_head_zero: assert property (tx_valid &&
        (idx_q inside {[2:5], 7}) |-> tx_beat.data == 8'h00)
        else $error("header byte not zero");
    a_ack_short: assert property (tx_valid && idx_q == 8'h07 &&
        type_q == 8'h80 |-> tx_beat.last) else $error("ack too long");
endmodule
bind app_service_frame_codec app_service_frame_codec_properties chk_u (
    .clk_sys(clk_sys), .nrst(nrst), .rx_drop_q(rx_drop_q),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat),
    .tx_tag(tx_tag), .ser_valid(ser_valid), .ser_ready(ser_ready),
    .ser_beat(ser_beat), .sample_start(sample_start),
    .sample_busy(sample_busy),
    .destination_ip_setting(destination_ip_setting));

// [dv/net_client_model.sv]
`timescale 1ns/1ns
// Client and serial sink; random stalls prove that no byte is lost.
module net_client_model (
    input wire logic clk_sys,
    output logic tx_ready,
    output logic ser_ready
);
    integer seed = 32'hbca67e89;
    initial begin
        tx_ready = 1'b0;
        ser_ready = 1'b0;
    end
    // Ready changes only just after an edge, never mid-cycle.
    always @(posedge clk_sys) begin
        tx_ready <= ($random(seed) % 3) != 0;
        ser_ready <= ($random(seed) % 4) != 0;
    end
endmodule

// [dv/app_service_frame_codec_tb.sv]
`timescale 1ns/1ns
module app_service_frame_codec_tb;
    import frame_codec_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic rx_valid = 1'b0;
    logic sample_start = 1'b0;
    byte_beat_t rx_beat = '0;
    sample_req_t sample_req = '0;
    logic [31:0] dest_ip = 32'h0A00_0017;
    logic rx_ready, ser_valid, tx_valid, sample_busy, rx_drop_q;
    logic tx_ready, ser_ready;
    byte_beat_t ser_beat, tx_beat;
    udp_tag_t tx_tag;
    logic [8:0] txq[$];
    logic [8:0] serq[$];
    logic [7:0] pl[4];
    integer seed = 32'hbca67e89;
    integer miscompares = 0;
    integer num_checks = 0;
    integer n;
    integer drops = 0;
    integer exp_drops = 0;
    always #5 clk_sys = ~clk_sys;
    app_service_frame_codec dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready),
        .ser_valid(ser_valid), .ser_beat(ser_beat), .ser_ready(ser_ready),
        .destination_ip_setting(dest_ip), .sample_start(sample_start),
        .sample_req(sample_req), .sample_busy(sample_busy),
        .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_tag(tx_tag),
        .tx_ready(tx_ready), .rx_drop_q(rx_drop_q));
    net_client_model peer_u (.clk_sys(clk_sys), .tx_ready(tx_ready),
        .ser_ready(ser_ready));
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task lapse;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        complete_run();
    endtask
    // Each delivered byte is matched with the oldest note; an extra one fails.
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && txq.size() != 0)
            check(tx_beat, txq.pop_front());
        else if (tx_valid === 1'b1 && tx_ready === 1'b1)
            check(9'h000, 9'h1FF);
        if (ser_valid === 1'b1 && ser_ready === 1'b1 && serq.size() != 0)
            check(ser_beat, serq.pop_front());
        else if (ser_valid === 1'b1 && ser_ready === 1'b1)
            check(9'h000, 9'h1FF);
        if (rx_drop_q === 1'b1) drops++;
    end
    // Request held until the edge that takes it.
    task put(input logic [7:0] d, input logic l);
        integer k;
        rx_valid <= 1'b1;
        rx_beat <= {d, l};
        for (k = 0; k < 500; k++) begin
            @(posedge clk_sys);
            if (rx_ready === 1'b1) break;
        end
        if (k == 500) lapse();
    endtask
    task settle;
        integer k;
        for (k = 0; k < 2000; k++) begin
            @(posedge clk_sys);
            if (txq.size() + serq.size() == 0 && sample_busy === 1'b0) break;
        end
        if (k == 2000) lapse();
    endtask
    task hdr(input logic [7:0] t, input logic l);
        integer i;
        logic [7:0] b[8];
        b = '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, t, 8'h00};
        for (i = 0; i < 8; i++) txq.push_back({b[i], l && i == 7});
    endtask
    // The client waits for the ack before the next command.
    task frame(input logic [15:0] w0, input logic [15:0] w1,
        input logic [7:0] t, input logic [7:0] o, input integer len);
        integer i;
        logic [7:0] h[8];
        h = '{w0[15:8], w0[7:0], w1[15:8], w1[7:0], 8'h00, 8'h00, t, o};
        if ((w0 ^ w1) != 16'h4242 || (t != 8'h00 && t != 8'h02 &&
            t != 8'h03)) exp_drops++;
        if ((w0 ^ w1) == 16'h4242 && t == 8'h00) begin
            for (i = 0; i < len; i++) serq.push_back({pl[i], i == len - 1});
            if (o[1]) hdr(8'h80, 1'b1);
        end
        for (i = 0; i < 8; i++) put(h[i], 1'b0);
        for (i = 0; i < len; i++) put(pl[i], i == len - 1);
        rx_valid <= 1'b0;
        settle();
    endtask
    task sample(input logic [15:0] dm, input logic [7:0] am);
        integer i;
        sample_req_t r;
        r.dig_mask = dm;
        r.ana_mask = am;
        r.dig_level = $random(seed);
        for (i = 0; i < 8; i++) r.ana_value[i] = $random(seed);
        hdr(8'h04, 1'b0);
        txq.push_back({8'h01, 1'b0});
        txq.push_back({dm[15:8], 1'b0});
        txq.push_back({dm[7:0], 1'b0});
        txq.push_back({am, 1'b0});
        if (dm != 16'h0000) begin
            txq.push_back({r.dig_level[15:8], 1'b0});
            txq.push_back({r.dig_level[7:0], 1'b0});
        end
        for (i = 0; i < 8; i++) begin
            if (am[i]) begin
                txq.push_back({6'h00, r.ana_value[i][9:8], 1'b0});
                txq.push_back({r.ana_value[i][7:0], 1'b0});
            end
        end
        txq[txq.size() - 1][0] = 1'b1;
        sample_req <= r;
        sample_start <= 1'b1;
        @(posedge clk_sys);
        sample_start <= 1'b0;
        settle();
    endtask
    initial begin
        for (n = 0; n < 4; n++) pl[n] = $random(seed);
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        dest_ip <= $random(seed);
        repeat (3) @(posedge clk_sys);
        frame(16'h4242, 16'h0000, 8'h00, 8'h02, 4);
        frame(16'h4242, 16'h0000, 8'h00, 8'h02, 4);
        frame(16'h1234, 16'h5076, 8'h00, 8'h02, 2);
        frame(16'h1234, 16'h1234, 8'h00, 8'h02, 3);
        frame(16'h0042, 16'h4200, 8'h55, 8'h02, 1);
        frame(16'h4242, 16'h0000, 8'h00, 8'h00, 1);
        frame(16'h4242, 16'h0000, 8'h02, 8'h00, 2);
        frame(16'h4242, 16'h0000, 8'h03, 8'h00, 2);
        for (n = 0; n < 4; n++)
            sample(n == 0 ? 16'h0000 : $random(seed), n == 1 ? 8'hFF : n);
        check(drops[8:0], exp_drops[8:0]);
        complete_run();
    end
endmodule
